// File: src/rss_pkg.sv
/*
 * Package for the start-up reset sequencer: timing counts, clock modes and
 * sequencer states.
 * Assumes a 100 MHz system clock; counts are in system clock cycles.
 */
package rss_pkg;

   // -----------------------------------------------------------------
   // Timing counts
   // -----------------------------------------------------------------
   localparam int unsigned RSS_PROBE_CYCLES   = 2;
   localparam int unsigned RSS_DRIVE_CYCLES   = 512;
   localparam int unsigned RSS_RELEASE_CYCLES = 10;
   localparam int unsigned RSS_CNT_W          = 10;

   // -----------------------------------------------------------------
   // Clock modes and reset causes
   // -----------------------------------------------------------------
   typedef enum logic {
      RSS_MODE_DIRECT = 1'b0,
      RSS_MODE_SYNTH  = 1'b1
   } rss_mode_t;

   typedef enum logic [1:0] {
      RSS_CAUSE_NONE     = 2'h0,
      RSS_CAUSE_POWER_ON = 2'h1,
      RSS_CAUSE_EXTERNAL = 2'h2
   } rss_cause_t;

   // Reset values.
   localparam logic [7:0] RSS_FREQ_RESET = 8'h00;

   typedef enum {
      RSS_ST_WAIT_CLOCK,
      RSS_ST_PROBE,
      RSS_ST_DRIVE,
      RSS_ST_RELEASE,
      RSS_ST_RUN
   } rss_state_t;

endpackage

// File: src/rss_sync_if.sv
/*
 * Interface carrying the synchronised reset-pin level from the synchroniser
 * to the sequencer.
 * Assumes both ends run on the same system clock.
 */
`timescale 1ns/1ns
`default_nettype none
interface rss_sync_if;
   logic pin_level;
   modport source (output pin_level);
   modport sink   (input  pin_level);
endinterface
`default_nettype wire

// File: src/rss_pin_sync.sv
/*
 * Two-stage synchroniser for the open-collector reset pin level.
 * Assumes the pin reads high when released, thanks to the board pull-up.
 */
`timescale 1ns/1ns
`default_nettype none
module rss_pin_sync (
   // Clock and reset
   input  wire logic   sys_clk,
   input  wire logic   reset,
   // Pin level in, synchronised level out
   input  wire logic   pin_in,
   rss_sync_if.source  sync
);
   logic meta;
   logic stable;

   // The first stage feeds only the second stage.
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         meta   <= 1'b0;
         stable <= 1'b0;
      end else begin
         meta   <= pin_in;   // see R14
         stable <= meta;
      end
   end

   assign sync.pin_level = stable;
endmodule
`default_nettype wire

// File: src/rss_sequencer.sv
/*
 * Start-up reset sequencer with clock-source selection.
 * Assumes the reset pin has an external pull-up and outside drivers only
 * pull low; the synthesizer and clock mux are analogue/clock cells outside.
 */
// Overview of operation
// R01 - Drive reset low until clock valid
// R02 - On lock, release line two cycles
// R03 - High during window means power-on reset
// R04 - Still low: external, drive 512 cycles
// R05 - After drive, release ten cycles
// R06 - High after release: start execution
// R07 - Low after release: repeat drive
// R08 - Outside drivers use open collector only
// R09 - Mode pin low in reset: direct clock
// R10 - Direct mode ignores frequency control bits
// R11 - Direct mode passes external clock unchanged
// R12 - Direct mode treats clock valid at once
// R13 - Mode pin high: synthesizer, external reference
// R14 - Reset pin synchronised in two stages
`timescale 1ns/1ns
`default_nettype none
module rss_sequencer #(
   parameter int unsigned DRIVE_CYCLES   = rss_pkg::RSS_DRIVE_CYCLES,
   parameter int unsigned RELEASE_CYCLES = rss_pkg::RSS_RELEASE_CYCLES,
   parameter int unsigned FREQ_W         = 8
) (
   // Clock and reset
   input  wire logic              sys_clk,
   input  wire logic              reset,
   // Open-collector reset pin
   input  wire logic              reset_pin_in,
   output logic                   reset_pin_out,
   output logic                   reset_pin_oe,
   // Clock source selection
   input  wire logic              clock_mode_select,
   input  wire logic              synth_lock,
   input  wire logic [FREQ_W-1:0] synth_freq_bits,
   output rss_pkg::rss_mode_t     clock_mode,
   output logic [FREQ_W-1:0]      synth_freq_ctrl,
   output logic                   synth_bypass,
   // Status
   output logic                   cpu_run,
   output rss_pkg::rss_cause_t    reset_cause
);
   import rss_pkg::*;

   // A window's verdict arrives in the third drive cycle, so shorter
   // drive phases cannot be served.
   if (DRIVE_CYCLES < 3 || DRIVE_CYCLES > (1 << RSS_CNT_W)) begin : g_bad_drive
      $error("DRIVE_CYCLES out of range");
   end
   if (RELEASE_CYCLES < 1 || RELEASE_CYCLES > DRIVE_CYCLES) begin : g_bad_release
      $error("RELEASE_CYCLES out of range");
   end

   // -----------------------------------------------------------------
   // Pin synchroniser
   // -----------------------------------------------------------------
   rss_sync_if sync_link ();

   rss_pin_sync u_sync (
      .sys_clk (sys_clk),
      .reset   (reset),
      .pin_in  (reset_pin_in),
      .sync    (sync_link.source)
   );

   logic pin_high;
   assign pin_high = sync_link.pin_level;   // see R14

   // -----------------------------------------------------------------
   // Clock mode capture
   // -----------------------------------------------------------------
   rss_state_t state;
   logic       clock_valid;

   // The mode pin is followed for as long as the part is in reset and
   // frozen once execution starts.
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         clock_mode <= RSS_MODE_SYNTH;
      end else if (state != RSS_ST_RUN) begin
         clock_mode <= rss_mode_t'(clock_mode_select);   // see R09 see R13
      end
   end

   assign synth_bypass = (clock_mode == RSS_MODE_DIRECT);   // see R11

   // Direct mode must not see frequency writes; the held value keeps the
   // synthesizer quiet rather than tracking software.
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         synth_freq_ctrl <= FREQ_W'(RSS_FREQ_RESET);
      end else if (clock_mode == RSS_MODE_SYNTH) begin
         synth_freq_ctrl <= synth_freq_bits;
      end   // see R10
   end

   assign clock_valid = synth_bypass | synth_lock;   // see R12

   // -----------------------------------------------------------------
   // Sequencer
   // -----------------------------------------------------------------
   logic [RSS_CNT_W-1:0] count;
   logic                 count_done;
   assign count_done = (count == '0);

   // The line level reaches pin_high two edges after it is sampled, so
   // each sample is tagged with whether the line was released when it
   // was taken. A window's verdict is known only once its last tagged
   // sample has come through, in the first cycles of the next drive.
   logic [1:0] in_window;
   logic       seen_high;
   logic       window_end;
   logic       window_high;
   logic       probe_phase;

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         in_window <= 2'h0;
      end else begin
         in_window <= {in_window[0], ~reset_pin_oe};   // see R14
      end
   end

   assign window_end  = in_window[1] & ~in_window[0];
   assign probe_phase = (reset_cause == RSS_CAUSE_NONE);
   // The probe accepts a high level anywhere in its window; a release
   // window counts only its last sample.
   assign window_high = pin_high | (probe_phase & seen_high);

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         seen_high <= 1'b0;
      end else if (window_end) begin
         seen_high <= 1'b0;
      end else if (in_window[1] && pin_high) begin
         seen_high <= 1'b1;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         state <= RSS_ST_WAIT_CLOCK;
         count <= '0;
      end else begin
         case (state)
            RSS_ST_WAIT_CLOCK: begin
               if (clock_valid) begin
                  state <= RSS_ST_PROBE;   // see R01
                  count <= RSS_CNT_W'(RSS_PROBE_CYCLES - 1);
               end
            end
            RSS_ST_PROBE: begin
               if (count_done) begin
                  state <= RSS_ST_DRIVE;   // see R02
                  count <= RSS_CNT_W'(DRIVE_CYCLES - 1);
               end else begin
                  count <= count - 1'b1;
               end
            end
            RSS_ST_DRIVE: begin
               // A power-on reset sees a short low pulse while its verdict
               // is still in the synchroniser; the window stays exact.
               if (window_end && window_high) begin
                  state <= RSS_ST_RUN;   // see R03 see R06
               end else if (count_done) begin
                  state <= RSS_ST_RELEASE;   // see R05
                  count <= RSS_CNT_W'(RELEASE_CYCLES - 1);
               end else begin
                  count <= count - 1'b1;
               end
            end
            RSS_ST_RELEASE: begin
               if (count_done) begin
                  state <= RSS_ST_DRIVE;   // see R07
                  count <= RSS_CNT_W'(DRIVE_CYCLES - 1);
               end else begin
                  count <= count - 1'b1;
               end
            end
            RSS_ST_RUN: begin
               state <= RSS_ST_RUN;
            end
            default: begin
               state <= RSS_ST_WAIT_CLOCK;
            end
         endcase
      end
   end

   // Reset cause is decided once, when the probe window's verdict arrives.
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         reset_cause <= RSS_CAUSE_NONE;
      end else if (state == RSS_ST_DRIVE && window_end && probe_phase) begin
         if (window_high) begin
            reset_cause <= RSS_CAUSE_POWER_ON;   // see R03
         end else begin
            reset_cause <= RSS_CAUSE_EXTERNAL;   // see R04
         end
      end
   end

   // -----------------------------------------------------------------
   // Pin drive and run flag
   // -----------------------------------------------------------------
   // Only ever pull low; outside drivers are open collector too, so the
   // line never fights a high driver.
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         reset_pin_oe <= 1'b1;   // see R01
      end else begin
         reset_pin_oe <= (state == RSS_ST_WAIT_CLOCK) || (state == RSS_ST_DRIVE);   // see R08
      end
   end

   assign reset_pin_out = 1'b0;

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         cpu_run <= 1'b0;
      end else begin
         cpu_run <= (state == RSS_ST_RUN);
      end
   end
endmodule
`default_nettype wire

// File: verif/rss_seq_properties.sv
/* Port checker for the reset sequencer, bound into rss_sequencer.
   Assumes DRIVE_CYCLES is 8 and RELEASE_CYCLES is 3, as the bench sets. */
`timescale 1ns/1ns
`default_nettype none
module rss_seq_properties #(
   parameter int unsigned DRIVE_CYCLES   = 8,
   parameter int unsigned RELEASE_CYCLES = 3,
   parameter int unsigned FREQ_W         = 8
) (
   // Clock and reset
   input wire logic                sys_clk,
   input wire logic                reset,
   // Watched ports
   input wire logic                reset_pin_out,
   input wire logic                reset_pin_oe,
   input wire logic                clock_mode_select,
   input wire logic                synth_lock,
   input wire logic [FREQ_W-1:0]   synth_freq_bits,
   input wire rss_pkg::rss_mode_t  clock_mode,
   input wire logic [FREQ_W-1:0]   synth_freq_ctrl,
   input wire logic                synth_bypass,
   input wire logic                cpu_run,
   input wire rss_pkg::rss_cause_t reset_cause
);
   import rss_pkg::*;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (reset);
   // Repetition counts are plain numbers; they match the bench's 8 and 3.
   sequence probe_win; !reset_pin_oe [*2]; endsequence
   sequence drive_win; reset_pin_oe [*8] ##1 !reset_pin_oe; endsequence
   // A high verdict ends a drive in its third cycle and starts the run.
   sequence early_run; reset_pin_oe [*3] ##1 (!reset_pin_oe && cpu_run); endsequence
   chk_data_low: assert property (reset_pin_out == 1'b0)
      else $error("reset pin data not low");
   chk_hold_invalid: assert property ($fell(reset_pin_oe) |->
      $past(synth_lock, 2) || $past(clock_mode, 2) == RSS_MODE_DIRECT)
      else $error("line released before clock valid");
   chk_probe_two: assert property ($fell(reset_pin_oe) &&
      reset_cause == RSS_CAUSE_NONE |-> probe_win ##1
      (reset_pin_oe || reset_cause == RSS_CAUSE_POWER_ON))
      else $error("probe window wrong");
   chk_drive_len: assert property ($rose(reset_pin_oe) |-> drive_win or early_run)
      else $error("drive length wrong");
   chk_release_len: assert property ($fell(reset_pin_oe) &&
      reset_cause == RSS_CAUSE_EXTERNAL |-> !reset_pin_oe [*3])
      else $error("release window too short");
   chk_run_free: assert property (cpu_run |->
      !reset_pin_oe && reset_cause != RSS_CAUSE_NONE)
      else $error("run while line driven");
   chk_run_sticks: assert property (cpu_run |=> cpu_run)
      else $error("run dropped");
   chk_bypass_mode: assert property (synth_bypass == (clock_mode == RSS_MODE_DIRECT))
      else $error("bypass not tied to mode");
   chk_freq_hold: assert property (clock_mode == RSS_MODE_DIRECT |=>
      $stable(synth_freq_ctrl)) else $error("frequency changed in direct mode");
   chk_freq_copy: assert property (clock_mode == RSS_MODE_SYNTH |=>
      synth_freq_ctrl == $past(synth_freq_bits)) else $error("frequency not taken");
   chk_mode_follow: assert property (!cpu_run |=>
      clock_mode == $past(clock_mode_select)) else $error("mode not following pin");
endmodule
bind rss_sequencer rss_seq_properties #(.DRIVE_CYCLES(DRIVE_CYCLES),
   .RELEASE_CYCLES(RELEASE_CYCLES), .FREQ_W(FREQ_W)) chk_i (.sys_clk, .reset,
   .reset_pin_out, .reset_pin_oe, .clock_mode_select, .synth_lock, .synth_freq_bits,
   .clock_mode, .synth_freq_ctrl, .synth_bypass, .cpu_run, .reset_cause);
`default_nettype wire

// File: verif/rss_far_side.sv
/* Far side of the reset line: pull-up, open-collector outside driver, lock.
   Assumes the bench commands the outside pull and the lock request. */
`timescale 1ns/1ns
`default_nettype none
module rss_far_side (
   // Clock
   input  wire logic sys_clk,
   // Device pin and commands
   input  wire logic dev_out,
   input  wire logic dev_oe,
   input  wire logic ext_pull,
   input  wire logic want_lock,
   // Line and lock
   output logic      line,
   output logic      synth_lock
);
   logic [2:0] settle = 3'h0;
   // Outside parties only pull low; the resistor gives the high.
   assign line = (dev_oe ? dev_out : 1'b1) & !ext_pull;
   // The loop takes a few cycles to settle, so lock is never prompt.
   always_ff @(posedge sys_clk) begin
      settle <= {settle[1:0], want_lock};
   end
   assign synth_lock = settle[2];
endmodule
`default_nettype wire

// File: verif/reset_startup_sequencer_test.sv
/* Self-checking bench for rss_sequencer with its far-side model.
   Assumes short counts of 8 drive and 3 release cycles. */
`timescale 1ns/1ns
`default_nettype none
module reset_startup_sequencer_test;
   import rss_pkg::*;
   logic sys_clk = 0, reset = 1, mode_sel = 1, ext_pull = 0, want_lock = 0;
   logic [7:0] freq_bits = 8'h00, freq_ctrl;
   logic line, lock, pin_out, pin_oe, bypass, run;
   rss_mode_t  mode;
   rss_cause_t cause;
   int n_fail = 0, checked = 0;
   always #5 sys_clk = ~sys_clk;
   rss_sequencer #(.DRIVE_CYCLES(8), .RELEASE_CYCLES(3)) dut (.sys_clk, .reset,
      .reset_pin_in(line), .reset_pin_out(pin_out), .reset_pin_oe(pin_oe),
      .clock_mode_select(mode_sel), .synth_lock(lock), .synth_freq_bits(freq_bits),
      .clock_mode(mode), .synth_freq_ctrl(freq_ctrl), .synth_bypass(bypass),
      .cpu_run(run), .reset_cause(cause));
   rss_far_side far (.sys_clk, .dev_out(pin_out), .dev_oe(pin_oe), .ext_pull,
      .want_lock, .line, .synth_lock(lock));
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checked++;
      if (got !== exp) begin
         n_fail++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic restart(input logic msel, input logic pull);
      reset <= 1'b1; mode_sel <= msel; ext_pull <= pull; want_lock <= 1'b0;
      repeat (16) @(posedge sys_clk);
      reset <= 1'b0;
   endtask
   task automatic wait_run();
      for (int i = 0; i < 60 && run !== 1'b1; i++) @(posedge sys_clk);
   endtask
   task automatic t_power_on();
      restart(1'b1, 1'b0);
      repeat (20) @(posedge sys_clk);
      chk(8'(pin_oe), 8'h01);
      want_lock <= 1'b1;
      wait_run();
      chk(8'(run), 8'h01);
      chk(8'(cause), 8'(RSS_CAUSE_POWER_ON));
      freq_bits <= 8'h5a;
      repeat (3) @(posedge sys_clk);
      chk(freq_ctrl, 8'h5a);
   endtask
   task automatic t_external();
      restart(1'b1, 1'b1);
      want_lock <= 1'b1;
      repeat (60) @(posedge sys_clk);
      chk(8'(run), 8'h00);
      chk(8'(cause), 8'(RSS_CAUSE_EXTERNAL));
      ext_pull <= 1'b0;
      wait_run();
      chk(8'(run), 8'h01);
      chk(8'(pin_oe), 8'h00);
   endtask
   task automatic t_direct();
      freq_bits <= 8'h00;
      restart(1'b0, 1'b0);
      wait_run();
      chk(8'(run), 8'h01);
      chk(8'(bypass), 8'h01);
      freq_bits <= 8'ha5;
      mode_sel <= 1'b1;
      repeat (3) @(posedge sys_clk);
      chk(freq_ctrl, 8'h00);
      chk(8'(mode), 8'(RSS_MODE_DIRECT));
   endtask
   task automatic conclude();
      $display("checked %0d n_fail %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   // A hang costs a mismatch; the three scenarios need well under 2000 cycles.
   initial begin
      #20000;
      n_fail++;
      conclude();
   end
   initial begin
      t_power_on();
      t_external();
      t_direct();
      conclude();
   end
endmodule
`default_nettype wire
